// ---- hw/acd_clock_ctrl.sv ----
// Operation
// - Stabilizer makes internal clock 50% duty
// - Loop idles below about 20 MHz
// - Unlocked stabilizer is bypassed, input duty passes
// - Strap mode: high strap pin enables stabilizer
// - Serial mode: enabled default, 0x00 disables
// - Divider ratio any integer 1 to 8
// - Even ratios give 50% duty inherently
// - Valid sync pulse resets divider counter
// - Sync on every pulse or first after write
// - Power-down from pin or serial register
// - Powered down: data drivers high impedance
// - Pin low returns to normal operation unless serial register selects power-down or standby
// - Strap low disables, high enables stabilizer
// - Pin remappable to power-down or standby
`include "acd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acd_clock_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_serial_mode_pin,
    input  wire logic        i_serial_io_stabilizer_strap_pin,
    input  wire logic        i_power_down_pin,
    input  wire logic        i_sync_pin,
    input  wire logic        i_rate_change,
    input  wire logic        i_rate_low,
    input  wire logic        i_reg_we,
    input  wire logic [12:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [1:0]  o_sample_clk_halves,
    output logic             o_stabilizer_active,
    output logic             o_stabilizer_locked,
    output logic             o_power_down,
    output logic             o_standby,
    output logic             o_data_oe,
    output logic             o_divider_wrap,
    output logic      [7:0]  o_reg_rdata
);
    import acd_pkg::*;

    acd_ctrl_state_t s_q;
    acd_ctrl_state_t s_d;
    acd_div_if       div_bus ();

    function automatic logic addr_hit(input logic [12:0] addr, input logic [12:0] target);
        addr_hit = (addr == target);
    endfunction

    logic       stab_en;
    logic       sync_edge;
    logic       sync_fire;
    logic       pin_standby;
    logic       pd_next;
    logic       sb_next;
    logic [3:0] ratio;
    logic [3:0] hi_first;
    logic [3:0] hi_second;
    logic [3:0] k_first;
    logic [3:0] k_second;

    // ****************************************
    // Divider
    // ****************************************
    acd_divider u_div (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .bus     (div_bus)
    );

    assign div_bus.ratio_m1 = s_q.div_reg[2:0];
    assign div_bus.sync     = s_q.div_sync;
    assign div_bus.hold     = s_q.power_down;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;

        // Two-stage pin synchronisers
        s_d.pin_meta = {i_sync_pin, i_power_down_pin,
                        i_serial_io_stabilizer_strap_pin, i_serial_mode_pin};
        s_d.pin_sync = s_q.pin_meta;

        // Register writes
        if (i_reg_we && addr_hit(i_reg_addr, `ACD_ADDR_STAB_CTRL)) begin
            s_d.stab_reg = i_reg_wdata;
        end
        if (i_reg_we && addr_hit(i_reg_addr, `ACD_ADDR_DIV_RATIO)) begin
            s_d.div_reg = {5'h00, i_reg_wdata[2:0]};
        end
        if (i_reg_we && addr_hit(i_reg_addr, `ACD_ADDR_PWR_MODE)) begin
            s_d.pwr_reg = i_reg_wdata;
        end
        if (i_reg_we && addr_hit(i_reg_addr, `ACD_ADDR_SYNC_CTRL)) begin
            s_d.sync_reg = i_reg_wdata;
        end

        // Stabilizer enable source
        if (s_q.pin_sync[`ACD_PIN_MODE]) begin
            stab_en = |s_q.stab_reg;
        end else begin
            stab_en = s_q.pin_sync[`ACD_PIN_STRAP];
        end

        // Sync pulse handling
        s_d.sync_prev = s_q.pin_sync[`ACD_PIN_SYNC];
        sync_edge = s_q.pin_sync[`ACD_PIN_SYNC] & ~s_q.sync_prev;
        sync_fire = sync_edge & s_q.sync_reg[`ACD_SYNC_EN_BIT]
                  & (~s_q.sync_reg[`ACD_SYNC_ONCE_BIT] | s_q.armed);
        s_d.div_sync = sync_fire;
        // A write that lands with a consuming pulse re-arms
        if (i_reg_we && addr_hit(i_reg_addr, `ACD_ADDR_SYNC_CTRL)) begin
            s_d.armed = 1'b1;
        end else if (sync_fire && s_q.sync_reg[`ACD_SYNC_ONCE_BIT]) begin
            s_d.armed = 1'b0;
        end

        // Relock tracking
        case (s_q.lock_st)
            ACD_LK_HUNT: begin
                if (i_rate_low) begin
                    s_d.lock_st = ACD_LK_LOW_RATE;
                end else if (i_rate_change) begin
                    s_d.lock_cnt = 10'h000;
                end else if (s_q.lock_cnt == 10'(`ACD_RELOCK_CYC - 1)) begin
                    s_d.lock_st  = ACD_LK_LOCKED;
                    s_d.lock_cnt = 10'h000;
                end else begin
                    s_d.lock_cnt = s_q.lock_cnt + 10'h001;
                end
            end
            ACD_LK_LOCKED: begin
                if (i_rate_low) begin
                    s_d.lock_st = ACD_LK_LOW_RATE;
                end else if (i_rate_change) begin
                    s_d.lock_st  = ACD_LK_HUNT;
                    s_d.lock_cnt = 10'h000;
                end
            end
            ACD_LK_LOW_RATE: begin
                if (!i_rate_low) begin
                    s_d.lock_st  = ACD_LK_HUNT;
                    s_d.lock_cnt = 10'h000;
                end
            end
            default: begin
                s_d.lock_st  = ACD_LK_HUNT;
                s_d.lock_cnt = 10'h000;
            end
        endcase
        s_d.locked      = (s_q.lock_st == ACD_LK_LOCKED);
        s_d.stab_active = stab_en && (s_q.lock_st == ACD_LK_LOCKED);

        // Internal clock shape in half periods of the input clock
        ratio     = {1'b0, s_q.div_reg[2:0]} + 4'h1;
        k_first   = {div_bus.count, 1'b0};
        k_second  = {div_bus.count, 1'b1};
        hi_first  = 4'((ratio + 4'h1) >> 1);
        hi_second = 4'(ratio >> 1);
        if (s_q.power_down) begin
            s_d.halves = 2'h0;
        end else if (s_d.stab_active) begin
            // Falling edge placed at exactly half the divided period
            s_d.halves = {k_first < ratio, k_second < ratio};
        end else begin
            // Edges follow whole input phases; even ratios still come out 50%
            s_d.halves = {{1'b0, div_bus.count} < hi_first,
                          {1'b0, div_bus.count} < hi_second};
        end
        s_d.wrap = div_bus.wrap;

        // Power modes; pin function only remappable in serial mode
        pin_standby = s_q.pin_sync[`ACD_PIN_MODE] & s_q.pwr_reg[`ACD_PWR_PIN_FUNC_BIT];
        pd_next = (s_q.pin_sync[`ACD_PIN_PDOWN] & ~pin_standby)
                | (s_q.pin_sync[`ACD_PIN_MODE]
                   & (s_q.pwr_reg[1:0] == `ACD_PWR_FULL));
        sb_next = ~pd_next
                & ((s_q.pin_sync[`ACD_PIN_PDOWN] & pin_standby)
                   | (s_q.pin_sync[`ACD_PIN_MODE]
                      & (s_q.pwr_reg[1:0] == `ACD_PWR_STANDBY)));
        s_d.power_down = pd_next;
        s_d.standby    = sb_next;
        s_d.data_oe    = ~(pd_next | sb_next);

        // Read port, one cycle behind the address
        s_d.rdata = 8'h00;
        if (addr_hit(i_reg_addr, `ACD_ADDR_STAB_CTRL)) begin
            s_d.rdata = s_q.stab_reg;
        end else if (addr_hit(i_reg_addr, `ACD_ADDR_DIV_RATIO)) begin
            s_d.rdata = s_q.div_reg;
        end else if (addr_hit(i_reg_addr, `ACD_ADDR_PWR_MODE)) begin
            s_d.rdata = s_q.pwr_reg;
        end else if (addr_hit(i_reg_addr, `ACD_ADDR_SYNC_CTRL)) begin
            s_d.rdata = s_q.sync_reg;
        end else if (addr_hit(i_reg_addr, `ACD_ADDR_STATUS)) begin
            s_d.rdata[`ACD_STAT_LOCKED_BIT] = s_q.locked;
            s_d.rdata[`ACD_STAT_ACTIVE_BIT] = s_q.stab_active;
            s_d.rdata[`ACD_STAT_PDOWN_BIT]  = s_q.power_down;
            s_d.rdata[`ACD_STAT_STBY_BIT]   = s_q.standby;
            s_d.rdata[`ACD_STAT_ARMED_BIT]  = s_q.armed;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q          <= '0;
            s_q.stab_reg <= `ACD_RST_STAB_CTRL;
            s_q.sync_reg <= `ACD_RST_SYNC_CTRL;
            s_q.div_reg  <= `ACD_RST_DIV_RATIO;
            s_q.pwr_reg  <= `ACD_RST_PWR_MODE;
            s_q.lock_st  <= ACD_LK_HUNT;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sample_clk_halves = s_q.halves;
    assign o_stabilizer_active = s_q.stab_active;
    assign o_stabilizer_locked = s_q.locked;
    assign o_power_down        = s_q.power_down;
    assign o_standby           = s_q.standby;
    assign o_data_oe           = s_q.data_oe;
    assign o_divider_wrap      = s_q.wrap;
    assign o_reg_rdata         = s_q.rdata;
endmodule

`default_nettype wire

// ---- hw/acd_defs.svh ----
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ACD_ADDR_PWR_MODE      13'h0008
`define ACD_ADDR_STAB_CTRL     13'h0009
`define ACD_ADDR_DIV_RATIO     13'h000B
`define ACD_ADDR_STATUS        13'h00FF
`define ACD_ADDR_SYNC_CTRL     13'h0100

// ****************************************
// Reset values
// ****************************************
`define ACD_RST_PWR_MODE       8'h00
`define ACD_RST_STAB_CTRL      8'h01
`define ACD_RST_DIV_RATIO      8'h00
`define ACD_RST_SYNC_CTRL      8'h00

// ****************************************
// Field positions
// ****************************************
`define ACD_SYNC_EN_BIT        1
`define ACD_SYNC_ONCE_BIT      2
`define ACD_PWR_FULL           2'h1
`define ACD_PWR_STANDBY        2'h2
`define ACD_PWR_PIN_FUNC_BIT   5
`define ACD_STAT_LOCKED_BIT    0
`define ACD_STAT_ACTIVE_BIT    1
`define ACD_STAT_PDOWN_BIT     2
`define ACD_STAT_STBY_BIT      3
`define ACD_STAT_ARMED_BIT     4

// ****************************************
// Pin synchroniser lanes
// ****************************************
`define ACD_PIN_MODE           0
`define ACD_PIN_STRAP          1
`define ACD_PIN_PDOWN          2
`define ACD_PIN_SYNC           3

// ****************************************
// Timing
// ****************************************
`define ACD_CLK_MHZ            200
`define ACD_RELOCK_NS          5000
`define ACD_RELOCK_CYC         ((`ACD_RELOCK_NS * `ACD_CLK_MHZ) / 1000)

`endif

// ---- hw/acd_pkg.sv ----
`default_nettype none

package acd_pkg;

    typedef enum logic [1:0] {
        ACD_LK_HUNT,
        ACD_LK_LOCKED,
        ACD_LK_LOW_RATE
    } acd_lock_t;

    typedef struct packed {
        logic [2:0] count;
        logic       wrap;
    } acd_div_state_t;

    typedef struct packed {
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic       sync_prev;
        logic [7:0] stab_reg;
        logic [7:0] sync_reg;
        logic [7:0] div_reg;
        logic [7:0] pwr_reg;
        logic       armed;
        acd_lock_t  lock_st;
        logic [9:0] lock_cnt;
        logic       div_sync;
        logic [1:0] halves;
        logic       stab_active;
        logic       locked;
        logic       power_down;
        logic       standby;
        logic       data_oe;
        logic       wrap;
        logic [7:0] rdata;
    } acd_ctrl_state_t;

endpackage

`default_nettype wire

// ---- hw/acd_div_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface acd_div_if;
    logic [2:0] ratio_m1;
    logic       sync;
    logic       hold;
    logic [2:0] count;
    logic       wrap;

    modport ctrl (output ratio_m1, output sync, output hold, input count, input wrap);
    modport div  (input ratio_m1, input sync, input hold, output count, output wrap);
endinterface

`default_nettype wire

// ---- hw/acd_divider.sv ----
`timescale 1ns/1ps
`default_nettype none

module acd_divider (
    input  wire logic i_clk,
    input  wire logic i_reset,
    acd_div_if.div    bus
);
    import acd_pkg::*;

    acd_div_state_t s_q;
    acd_div_state_t s_d;

    // ****************************************
    // Counter
    // ****************************************
    always_comb begin
        s_d      = s_q;
        s_d.wrap = 1'b0;
        if (bus.sync || bus.hold) begin
            s_d.count = 3'h0;
        end else if (s_q.count >= bus.ratio_m1) begin
            // Ratio lowered mid-period: wrap at once instead of running past
            s_d.count = 3'h0;
            s_d.wrap  = 1'b1;
        end else begin
            s_d.count = s_q.count + 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.count = s_q.count;
    assign bus.wrap  = s_q.wrap;
endmodule

`default_nettype wire

// ---- dv/acd_clock_ctrl_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module acd_clock_ctrl_asserts (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_serial_mode_pin,
    input wire logic        i_serial_io_stabilizer_strap_pin,
    input wire logic        i_power_down_pin,
    input wire logic        i_rate_change,
    input wire logic        i_rate_low,
    input wire logic        i_reg_we,
    input wire logic [12:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [1:0]  o_sample_clk_halves,
    input wire logic        o_stabilizer_active,
    input wire logic        o_stabilizer_locked,
    input wire logic        o_power_down,
    input wire logic        o_standby,
    input wire logic        o_data_oe
);
    // ********
    // Checks
    // ********
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    AST_PD_HIZ: assert property ((o_power_down || o_standby) |-> !o_data_oe)
        else $error("data drivers on while powered down");
    AST_PD_CLK: assert property (o_power_down [*2] |-> o_sample_clk_halves == 2'b00)
        else $error("internal clock runs in power-down");
    AST_PIN_PD: assert property (i_power_down_pin [*4] |=> (o_power_down || o_standby))
        else $error("power-down pin ignored");
    AST_PIN_WAKE: assert property ((!i_power_down_pin && !i_serial_mode_pin) [*4]
        |=> (!o_power_down && !o_standby && o_data_oe)) else $error("no wake from pin");
    AST_STRAP_ON: assert property (
        (!i_serial_mode_pin && i_serial_io_stabilizer_strap_pin) [*4]
        |=> o_stabilizer_active == o_stabilizer_locked) else $error("strap high not enabling");
    AST_STRAP_OFF: assert property (
        (!i_serial_mode_pin && !i_serial_io_stabilizer_strap_pin) [*4]
        |=> !o_stabilizer_active) else $error("strap low not disabling");
    AST_BYPASS: assert property (o_stabilizer_active |-> o_stabilizer_locked)
        else $error("correcting while unlocked");
    AST_RELOCK: assert property (i_rate_change
        |-> ##2 (!o_stabilizer_locked && !o_stabilizer_active) [*8])
        else $error("no relock after rate change");
    AST_SLOW: assert property (i_rate_low [*2] |=> !o_stabilizer_locked)
        else $error("loop locked at low rate");
    AST_SPI_OFF: assert property (i_serial_mode_pin [*4]
        ##0 (i_reg_we && i_reg_addr == 13'h0009 && i_reg_wdata == 8'h00)
        |-> ##2 !o_stabilizer_active) else $error("disable write ignored");
endmodule

bind acd_clock_ctrl acd_clock_ctrl_asserts acd_clock_ctrl_asserts_i (.i_clk, .i_reset,
    .i_serial_mode_pin, .i_serial_io_stabilizer_strap_pin, .i_power_down_pin, .i_rate_change,
    .i_rate_low, .i_reg_we, .i_reg_addr, .i_reg_wdata, .o_sample_clk_halves, .o_stabilizer_active,
    .o_stabilizer_locked, .o_power_down, .o_standby, .o_data_oe);

`default_nettype wire

// ---- dv/acd_sync_src.sv ----
`timescale 1ns/1ps
`default_nettype none

module acd_sync_src (
    input  wire logic i_clk,
    input  wire logic i_fire,
    input  wire logic i_new_rate,
    input  wire logic i_slow,
    output logic      o_sync_pin,
    output logic      o_rate_change,
    output logic      o_rate_low
);
    logic [2:0] width_q = 3'h0;
    logic       chg_q   = 1'b0;
    logic       low_q   = 1'b0;

    // Sync held low between pulses so it never floats
    always_ff @(posedge i_clk) begin
        if (i_fire) begin
            width_q <= 3'h4;
        end else if (width_q != 3'h0) begin
            width_q <= width_q - 3'h1;
        end
        chg_q <= i_new_rate;
        low_q <= i_slow;
    end
    assign o_sync_pin    = (width_q != 3'h0);
    assign o_rate_change = chg_q;
    assign o_rate_low    = low_q;
endmodule

`default_nettype wire

// ---- dv/acd_clock_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module acd_clock_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, mode = 1'b1, strap = 1'b1, pdp = 1'b0;
    logic        fire = 1'b0, newr = 1'b0, slow = 1'b0, we = 1'b0, rdf = 1'b0, rf_q = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [1:0]  halves;
    logic        sync, rchg, rlow, act, lck, pd, sb, oe, wrap;
    logic [15:0] q[$], e;
    int          miscompares = 0, checks = 0;
    logic [19:0] pt [7] = '{20'h1_0014, 20'h1_0028, 20'h1_1208, 20'h1_1004, 20'h1_0000,
                            20'h0_1004, 20'h0_0000};

    acd_clock_ctrl acd_clock_ctrl_i (.i_clk(clk), .i_reset(rst), .i_serial_mode_pin(mode),
        .i_serial_io_stabilizer_strap_pin(strap), .i_power_down_pin(pdp), .i_sync_pin(sync),
        .i_rate_change(rchg), .i_rate_low(rlow), .i_reg_we(we), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_sample_clk_halves(halves), .o_stabilizer_active(act),
        .o_stabilizer_locked(lck), .o_power_down(pd), .o_standby(sb), .o_data_oe(oe),
        .o_divider_wrap(wrap), .o_reg_rdata(rdata));
    acd_sync_src acd_sync_src_i (.i_clk(clk), .i_fire(fire), .i_new_rate(newr), .i_slow(slow),
        .o_sync_pin(sync), .o_rate_change(rchg), .o_rate_low(rlow));

    // ********
    // Tasks
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [12:0] ad, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // Expected value and mask are queued for the monitor
    task automatic rd(input logic [12:0] ad, input logic [7:0] x, input logic [7:0] m);
        @(posedge clk);
        addr <= ad;
        rdf <= 1'b1;
        q.push_back({x, m});
        @(posedge clk);
        rdf <= 1'b0;
    endtask
    task automatic ww(output int n, output int h);
        n = 0;
        h = 0;
        do begin
            @(negedge clk);
            n++;
            h += $countones(halves);
        end while (wrap !== 1'b1 && n < 40);
    endtask
    // Fires a sync pulse k cycles after a wrap, then times the next wrap
    task automatic sy(input int k, output int d);
        int h;
        ww(d, h);
        repeat (k) @(negedge clk);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (6) @(negedge clk);
        ww(d, h);
    endtask

    always @(posedge clk) begin
        rf_q <= rdf;
        if (rf_q && q.size() > 0) begin
            e = q.pop_front();
            check(rdata & e[7:0], e[15:8]);
        end
    end

    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        int a, b, x, y, n, h;
        void'($urandom(94));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(13'h0009, 8'h01, 8'hFF);
        rd(13'h000B, 8'h00, 8'hFF);
        rd(13'h0123, 8'h00, 8'hFF);
        wr(13'h00FF, 8'hFF);
        rd(13'h00FF, 8'h00, 8'hFF);
        repeat (1010) @(posedge clk);
        rd(13'h00FF, 8'h03, 8'h03);
        check(8'({act, lck}), 8'h03);
        wr(13'h0009, 8'h00);
        rd(13'h00FF, 8'h01, 8'h03);
        wr(13'h0009, 8'(1 + $urandom % 255));
        newr <= 1'b1;
        @(posedge clk);
        newr <= 1'b0;
        repeat (4) @(posedge clk);
        rd(13'h00FF, 8'h00, 8'h03);
        slow <= 1'b1;
        repeat (1010) @(posedge clk);
        rd(13'h00FF, 8'h00, 8'h03);
        check(8'({act, lck}), 8'h00);
        slow <= 1'b0;
        repeat (1010) @(posedge clk);
        rd(13'h00FF, 8'h03, 8'h03);
        mode <= 1'b0;
        strap <= 1'b0;
        repeat (5) @(posedge clk);
        rd(13'h00FF, 8'h00, 8'h02);
        strap <= 1'b1;
        repeat (5) @(posedge clk);
        rd(13'h00FF, 8'h02, 8'h02);
        for (int i = 0; i < 7; i++) begin
            mode <= pt[i][16];
            pdp <= pt[i][12];
            wr(13'h0008, pt[i][11:4]);
            repeat (5) @(posedge clk);
            rd(13'h00FF, {4'h0, pt[i][3:0]}, 8'h0C);
            check(8'({pd, sb, oe}), {5'h00, pt[i][2], pt[i][3], ~(pt[i][2] | pt[i][3])});
        end
        for (int r = 2; r <= 8; r++) begin
            wr(13'h000B, {5'($urandom), 3'(r - 1)});
            rd(13'h000B, 8'(r - 1), 8'hFF);
            ww(n, h);
            ww(n, h);
            check(8'(n), 8'(r));
            check(8'(h), 8'(r));
        end
        wr(13'h0100, 8'h02);
        sy(0, a);
        sy(3, b);
        check(8'(a), 8'h08);
        check(8'(b), 8'(a));
        wr(13'h0100, 8'h06);
        rd(13'h00FF, 8'h10, 8'h10);
        sy(3, b);
        check(8'(b), 8'(a));
        rd(13'h00FF, 8'h00, 8'h10);
        sy(0, x);
        sy(3, y);
        check(8'((x - y) & 7), 8'h03);
        wr(13'h0100, 8'h00);
        sy(0, x);
        sy(3, y);
        check(8'((x - y) & 7), 8'h03);
        repeat (4) @(posedge clk);
        check(8'(q.size()), 8'h00);
        close_out();
    end
endmodule

`default_nettype wire
